// ---- csf_serial_status.sv ----
// four clocked serial ports with their status registers and interrupts
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module csf_serial_status (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic [csf_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [csf_pkg::DATA_W-1:0]    wdata,
  input  wire logic [csf_pkg::DATA_W/8-1:0]  wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [csf_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [csf_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic [csf_pkg::NPORT-1:0]     sclk,
  input  wire logic [csf_pkg::NPORT-1:0]     rxd,
  output logic      [csf_pkg::NPORT-1:0]     txd,
  output logic                               irq
);

  localparam int NP = csf_pkg::NPORT;
  localparam int BW = csf_pkg::BYTE_W;

  // =====================================================================
  // state
  typedef struct packed {
    logic [BW-1:0] rx_sh;
    logic [2:0]    rx_cnt;
    logic [BW-1:0] rx_buf;
    logic          rx_full;
    logic          ovr;
    logic [BW-1:0] tx_buf;
    logic          tx_full;
    logic [BW-1:0] tx_sh;
    logic [2:0]    tx_cnt;
    logic          busy;
    logic          tx_pend;
    logic          txd;
    logic          sclk_d;
  } csf_port_t;

  typedef struct packed {
    csf_port_t [NP-1:0] port;
    logic [2*NP-1:0]    int_stat;
    logic [2*NP-1:0]    int_mask;
    logic               irq;
  } csf_state_t;

  csf_state_t                          s;
  csf_state_t                          next_s;
  logic                                wr_en;
  logic [csf_pkg::ADDR_W-1:0]          wr_addr;
  logic [BW-1:0]                       wr_data;
  logic                                wr_be;
  logic                                wr_err;
  logic                                rd_en;
  logic [csf_pkg::ADDR_W-1:0]          rd_addr;
  logic [BW-1:0]                       rd_data;
  logic                                rd_err;
  logic [csf_pkg::IDX_W-1:0]           wr_idx;
  logic [csf_pkg::IDX_W-1:0]           rd_idx;
  logic [NP-1:0]                       sy_clk;
  logic [NP-1:0]                       sy_rxd;
  logic [NP-1:0]                       rise;
  logic [NP-1:0]                       fall;
  logic [NP-1:0]                       rx_done;
  logic [NP-1:0]                       rx_rd;
  logic [NP-1:0]                       tx_wr;
  logic [NP-1:0]                       tx_take;
  logic [NP-1:0]                       stat_wr;
  logic [NP-1:0][BW-1:0]               stat;
  logic [2*NP-1:0]                     int_req;
  logic [2*NP-1:0]                     int_clr;

  // =====================================================================
  // bus slave
  csf_axil u_axil (
    .mclk    (mclk),
    .resetn  (resetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_be   (wr_be),
    .wr_err  (wr_err),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // =====================================================================
  // link pins; clock and data pass the same two stages so they stay aligned
  csf_sync #(
    .W (2*NP)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      ({rxd, sclk}),
    .q      ({sy_rxd, sy_clk})
  );

  assign wr_idx = wr_addr[csf_pkg::ADDR_W-1:2];
  assign rd_idx = rd_addr[csf_pkg::ADDR_W-1:2];

  // =====================================================================
  // per-port serial logic, register decode and interrupts
  always_comb
  begin
    next_s  = s;
    rise    = '0;
    fall    = '0;
    rx_done = '0;
    rx_rd   = '0;
    tx_wr   = '0;
    tx_take = '0;
    stat_wr = '0;
    stat    = '0;
    rd_data = '0;
    rd_err  = 1'b1;
    wr_err  = 1'b1;
    int_req = '0;
    int_clr = '0;
    for (int p = 0; p < NP; p++)
    begin
      // status image; unlisted bits stay at zero
      stat[p][csf_pkg::RXF_BIT]  = s.port[p].rx_full;
      stat[p][csf_pkg::OVR_BIT]  = s.port[p].ovr;
      stat[p][csf_pkg::TXF_BIT]  = s.port[p].tx_full;
      stat[p][csf_pkg::BUSY_BIT] = s.port[p].busy;
      // reads and writes that belong to this port
      if (rd_idx == csf_pkg::STAT_IDX[p])
      begin
        rd_data = stat[p] & ~csf_pkg::RSVD_MASK;
        rd_err  = 1'b0;
      end
      if (rd_idx == csf_pkg::DATA_IDX[p])
      begin
        rd_data  = s.port[p].rx_buf;
        rd_err   = 1'b0;
        rx_rd[p] = rd_en;
      end
      if (wr_idx == csf_pkg::STAT_IDX[p])
      begin
        wr_err     = 1'b0;
        stat_wr[p] = wr_en;  // value ignored
      end
      if (wr_idx == csf_pkg::DATA_IDX[p])
      begin
        wr_err   = 1'b0;
        tx_wr[p] = wr_en & wr_be;
      end
      // edges of the peer's clock, seen on the synchronised copy
      next_s.port[p].sclk_d = sy_clk[p];
      rise[p] = sy_clk[p] & ~s.port[p].sclk_d;
      fall[p] = ~sy_clk[p] & s.port[p].sclk_d;
      // receive: sample on rising edge, lsb first
      rx_done[p] = rise[p] && (s.port[p].rx_cnt == csf_pkg::LAST_BIT);
      next_s.port[p].rx_full = s.port[p].rx_full & ~rx_rd[p];
      next_s.port[p].ovr     = s.port[p].ovr & ~rx_rd[p];
      if (rise[p])
      begin
        next_s.port[p].rx_sh  = {sy_rxd[p], s.port[p].rx_sh[BW-1:1]};
        next_s.port[p].rx_cnt = s.port[p].rx_cnt + 3'h1;
      end
      // a byte landing in the cycle of the read goes into the freed buffer
      if (rx_done[p])
      begin
        if (next_s.port[p].rx_full)
          next_s.port[p].ovr = 1'b1;
        else
        begin
          next_s.port[p].rx_buf  = {sy_rxd[p], s.port[p].rx_sh[BW-1:1]};
          next_s.port[p].rx_full = 1'b1;
        end
      end
      // transmit: take a byte when idle or when the last bit ends
      tx_take[p] = fall[p] && s.port[p].tx_full &&
                   (!s.port[p].busy || s.port[p].tx_cnt == csf_pkg::LAST_BIT);
      if (tx_take[p])
      begin
        next_s.port[p].tx_sh   = s.port[p].tx_buf;
        next_s.port[p].txd     = s.port[p].tx_buf[0];
        next_s.port[p].tx_cnt  = '0;
        next_s.port[p].busy    = 1'b1;
        next_s.port[p].tx_full = 1'b0;
      end
      else if (fall[p] && s.port[p].busy && s.port[p].tx_cnt == csf_pkg::LAST_BIT)
        next_s.port[p].busy = 1'b0;  // nothing queued
      else if (fall[p] && s.port[p].busy)
      begin
        next_s.port[p].tx_sh  = {1'b0, s.port[p].tx_sh[BW-1:1]};
        next_s.port[p].txd    = s.port[p].tx_sh[1];
        next_s.port[p].tx_cnt = s.port[p].tx_cnt + 3'h1;
      end
      // a write while a byte waits replaces it; a write that meets a take stays
      if (tx_wr[p])
      begin
        next_s.port[p].tx_buf  = wr_data;
        next_s.port[p].tx_full = 1'b1;
      end
      // pending transmit request: clear first so a take in the same cycle wins
      if (tx_wr[p] || stat_wr[p])
        next_s.port[p].tx_pend = 1'b0;
      if (tx_take[p])
        next_s.port[p].tx_pend = 1'b1;
      // request levels feeding the sticky bits
      int_req[p]    = s.port[p].rx_full;
      int_req[p+NP] = s.port[p].tx_pend;
    end
    // interrupt registers; set wins over write-one-to-clear
    if (rd_idx == csf_pkg::INT_STAT_IDX)
    begin
      rd_data = s.int_stat;
      rd_err  = 1'b0;
    end
    if (rd_idx == csf_pkg::INT_MASK_IDX)
    begin
      rd_data = s.int_mask;
      rd_err  = 1'b0;
    end
    if (wr_idx == csf_pkg::INT_STAT_IDX)
    begin
      wr_err  = 1'b0;
      int_clr = (wr_en && wr_be) ? wr_data : '0;
    end
    if (wr_idx == csf_pkg::INT_MASK_IDX)
    begin
      wr_err = 1'b0;
      if (wr_en && wr_be)
        next_s.int_mask = wr_data;
    end
    next_s.int_stat = (s.int_stat & ~int_clr) | int_req;
    next_s.irq      = |(next_s.int_stat & next_s.int_mask);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  // =====================================================================
  // outputs, all from flops
  always_comb
  begin
    for (int p = 0; p < NP; p++)
      txd[p] = s.port[p].txd;
  end

  assign irq = s.irq;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  generate
    for (genvar g = 0; g < NP; g++)
    begin : g_chk
      rx_full_set_a : assert property (
        rx_done[g] && !s.port[g].rx_full |=> s.port[g].rx_full)
        else $error("receive byte did not set the full bit");
      rx_empty_a : assert property (
        rx_rd[g] && !rx_done[g] |=> !s.port[g].rx_full)
        else $error("receive read did not empty the buffer");
      rx_irq_a : assert property (
        s.port[g].rx_full |=> s.int_stat[g])
        else $error("receive request missing while buffer full");
      rsvd_zero_a : assert property (
        rx_rd[g] || !rd_en || rd_idx != csf_pkg::STAT_IDX[g] ||
        (rd_data & csf_pkg::RSVD_MASK) == '0)
        else $error("reserved status bits read nonzero");
      ovr_set_a : assert property (
        rx_done[g] && s.port[g].rx_full && !rx_rd[g] |=> s.port[g].ovr)
        else $error("overrun not flagged");
      ovr_clr_a : assert property (
        rx_rd[g] && !rx_done[g] |=> !s.port[g].ovr)
        else $error("overrun not cleared by receive read");
      tx_full_a : assert property (
        tx_take[g] && !tx_wr[g] |=> !s.port[g].tx_full ##1 $stable(s.port[g].tx_full)
        or tx_wr[g])
        else $error("transmit full bit wrong after take");
      tx_irq_set_a : assert property (
        tx_take[g] |=> s.port[g].tx_pend ##1 s.int_stat[g+NP])
        else $error("take did not raise transmit request");
      tx_irq_clr_a : assert property (
        (tx_wr[g] || stat_wr[g]) && !tx_take[g] |=> !s.port[g].tx_pend)
        else $error("transmit request not cleared by write");
      busy_a : assert property (
        tx_take[g] |=> s.port[g].busy && s.port[g].tx_cnt == '0)
        else $error("busy not set when byte loaded");
      busy_drop_a : assert property (
        $fell(s.port[g].busy) |-> !$past(s.port[g].tx_full) &&
        $past(s.port[g].tx_cnt) == csf_pkg::LAST_BIT)
        else $error("busy dropped early or with byte queued");
    end
  endgenerate

  irq_out_a : assert property (
    s.irq == |(s.int_stat & s.int_mask))
    else $error("interrupt output disagrees with masked status");

endmodule

// ---- csf_pkg.sv ----
// constants shared by the clocked serial status block
package csf_pkg;

  // =====================================================================
  // sizes
  localparam int NPORT  = 4;
  localparam int ADDR_W = 10;
  localparam int IDX_W  = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // =====================================================================
  // register indices, byte address is four times the index
  localparam logic [NPORT-1:0][IDX_W-1:0] STAT_IDX = {8'hf3, 8'he3, 8'hd3, 8'hc3};
  localparam logic [NPORT-1:0][IDX_W-1:0] DATA_IDX = {8'hf0, 8'he0, 8'hd0, 8'hc0};
  localparam logic [IDX_W-1:0] INT_STAT_IDX = 8'h80;
  localparam logic [IDX_W-1:0] INT_MASK_IDX = 8'h81;

  // =====================================================================
  // status register fields
  localparam int RXF_BIT  = 7;
  localparam int OVR_BIT  = 5;
  localparam int TXF_BIT  = 3;
  localparam int BUSY_BIT = 2;
  localparam logic [BYTE_W-1:0] RSVD_MASK = 8'h53;

  // =====================================================================
  // serial framing and bus answers
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- csf_sync.sv ----
// two flip-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/1ps
module csf_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csf_sync_t;

  csf_sync_t s;
  csf_sync_t next_s;

  // =====================================================================
  // first stage feeds only the second one
  always_comb
  begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.s2;

endmodule

// ---- csf_axil.sv ----
// axi4-lite slave front end with one write and one read in flight
`timescale 1ns/1ps
module csf_axil (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic [csf_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [csf_pkg::DATA_W-1:0]    wdata,
  input  wire logic [csf_pkg::DATA_W/8-1:0]  wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [csf_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [csf_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic                               wr_en,
  output logic [csf_pkg::ADDR_W-1:0]         wr_addr,
  output logic [csf_pkg::BYTE_W-1:0]         wr_data,
  output logic                               wr_be,
  input  wire logic                          wr_err,
  output logic                               rd_en,
  output logic [csf_pkg::ADDR_W-1:0]         rd_addr,
  input  wire logic [csf_pkg::BYTE_W-1:0]    rd_data,
  input  wire logic                          rd_err
);

  typedef struct packed {
    logic                       aw_have;
    logic [csf_pkg::ADDR_W-1:0] aw_addr;
    logic                       w_have;
    logic [csf_pkg::BYTE_W-1:0] w_data;
    logic                       w_be;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [csf_pkg::DATA_W-1:0] rdata;
    logic [1:0]                 rresp;
  } csf_axil_t;

  csf_axil_t s;
  csf_axil_t next_s;

  // =====================================================================
  // address and data latch on their own, the write fires once both are held
  always_comb
  begin
    next_s  = s;
    wr_en   = s.aw_have & s.w_have & ~s.bvalid;
    wr_addr = s.aw_addr;
    wr_data = s.w_data;
    wr_be   = s.w_be;
    rd_en   = s.arready & arvalid;
    rd_addr = araddr;
    if (s.awready && awvalid)
    begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (s.wready && wvalid)
    begin
      next_s.w_have = 1'b1;
      next_s.w_data = wdata[csf_pkg::BYTE_W-1:0];
      next_s.w_be   = wstrb[0];
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (wr_en)
    begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_err ? csf_pkg::RESP_SLVERR : csf_pkg::RESP_OKAY;
    end
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    // read data is captured at the handshake so side effects happen once
    if (rd_en)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = {{(csf_pkg::DATA_W-csf_pkg::BYTE_W){1'b0}}, rd_data};
      next_s.rresp  = rd_err ? csf_pkg::RESP_SLVERR : csf_pkg::RESP_OKAY;
    end
    next_s.awready = ~next_s.aw_have & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_have & ~next_s.bvalid;
    next_s.arready = ~next_s.rvalid;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;

endmodule

// ---- csf_peer.sv ----
// behavioural clocked serial peer that clocks and feeds the four ports
`timescale 1ns/1ps
module csf_peer (
  input  wire logic [3:0] txd,
  output logic      [3:0] sclk,
  output logic      [3:0] rxd,
  output logic      [7:0] got
);
  // =====================================================================
  // idle state
  // clock stands low outside frames, so the receiver sees no stray edge
  initial
  begin
    sclk = '0;
    rxd  = '0;
    got  = '0;
  end

  // =====================================================================
  // one burst of n clocks on port p, 125 ns period
  // data lsb first; txd sampled on each rising edge, newest bit at msb
  task automatic xfer(input int p, input int n, input logic [7:0] d);
    for (int i = 0; i < n; i++)
    begin
      rxd[p]  = d[i%8];
      #62.5;
      sclk[p] = 1'b1;
      got     = {txd[p], got[7:1]};
      #62.5;
      sclk[p] = 1'b0;
    end
    #62.5;
    // released line shows the inverse, never a stale level
    rxd[p] = ~rxd[p];
  endtask
endmodule

// ---- clocked_serial_status_flags_tb.sv ----
// self-checking bench for the clocked serial status block over axi4-lite
`timescale 1ns/1ps
module clocked_serial_status_flags_tb;
  // =====================================================================
  // signals
  localparam logic [1:0] OK  = csf_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = csf_pkg::RESP_SLVERR;
  localparam logic [9:0] IS  = {csf_pkg::INT_STAT_IDX, 2'b00};
  localparam logic [9:0] IM  = {csf_pkg::INT_MASK_IDX, 2'b00};
  logic        mclk    = 1'b0;
  logic        resetn  = 1'b0;
  logic [9:0]  awaddr  = '0;
  logic [9:0]  araddr  = '0;
  logic [31:0] wdata   = '0;
  logic [3:0]  wstrb   = '0;
  logic [3:0]  strb    = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  sclk, rxd, txd;
  int          num_errors = 0;
  int          checked    = 0;

  always #5 mclk = ~mclk;

  csf_serial_status DUT (.mclk(mclk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sclk(sclk), .rxd(rxd), .txd(txd), .irq(irq));
  csf_peer PEER (.txd(txd), .sclk(sclk), .rxd(rxd), .got());

  // =====================================================================
  // helpers
  function automatic logic [9:0] sa(input int p);
    return {csf_pkg::STAT_IDX[p], 2'b00};
  endfunction
  function automatic logic [9:0] da(input int p);
    return {csf_pkg::DATA_IDX[p], 2'b00};
  endfunction

  task automatic close_out;
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // irq is registered, so look at it half a cycle after the edge
  task automatic ck_irq(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // =====================================================================
  // bus cycles: handshakes judged from values settled before the edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    bit         ah, wh, bh;
    logic [1:0] r;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bh = 0;
    for (int n = 0; n < 50 && !bh; n++)
    begin
      @(negedge mclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      r  = bresp;
      @(posedge mclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh)
    begin
      num_errors++;
      close_out;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er);
    bit          ah, rh;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rh = 0;
    for (int n = 0; n < 50 && !rh; n++)
    begin
      @(negedge mclk);
      ah = arvalid & arready;
      rh = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge mclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh)
    begin
      num_errors++;
      close_out;
    end
    chk(d, {24'h0, ed});
    chk({30'h0, r}, {30'h0, er});
  endtask

  // =====================================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    for (int p = 0; p < 4; p++) rd(sa(p), 8'h00, OK); // all clear
    rd(IS, 8'h00, OK);
    rd(IM, 8'h00, OK);
    rd(10'h004, 8'h00, ERR);
    wr(10'h004, 8'hff, ERR);
    wr(IM, 8'hff, OK);
    rd(IM, 8'hff, OK);
    // low strobe lane off: the write is answered but stores nothing
    strb = 4'h0;
    wr(IM, 8'h00, OK);
    strb = 4'hf;
    rd(IM, 8'hff, OK);
    // receive, overrun and buffer read on port a
    PEER.xfer(0, 8, 8'ha5);
    rd(sa(0), 8'h80, OK); // byte waiting
    ck_irq(1'b1); // request up
    wr(IS, 8'h01, OK);
    rd(IS, 8'h01, OK); // re-sets while full
    wr(IM, 8'h00, OK);
    ck_irq(1'b0);
    wr(IM, 8'hff, OK);
    PEER.xfer(0, 8, 8'h3c);
    rd(sa(0), 8'ha0, OK); // overrun flag
    rd(da(0), 8'ha5, OK); // later byte dropped
    rd(sa(0), 8'h00, OK); // both cleared by read
    wr(IS, 8'h01, OK);
    rd(IS, 8'h00, OK);
    ck_irq(1'b0); // buffer empty
    // transmit two bytes back to back on port b
    wr(da(1), 8'h96, OK);
    rd(sa(1), 8'h08, OK); // buffer full
    PEER.xfer(1, 1, 8'h00);
    rd(sa(1), 8'h04, OK); // taken and shifting
    rd(IS, 8'h20, OK); // take raises request
    wr(da(1), 8'h5a, OK);
    rd(sa(1), 8'h0c, OK);
    wr(IS, 8'h20, OK);
    rd(IS, 8'h00, OK); // buffer write cleared it
    PEER.xfer(1, 7, 8'h00);
    rd(sa(1), 8'h8c, OK); // still busy on last bit
    rd(da(1), 8'h00, OK);
    wr(IS, 8'hff, OK);
    PEER.xfer(1, 1, 8'h00);
    chk({24'h0, PEER.got}, 32'h96); // first byte on the wire
    rd(sa(1), 8'h04, OK); // reload keeps busy
    rd(IS, 8'h20, OK); // second take
    wr(sa(1), 8'h00, OK);
    wr(IS, 8'h20, OK);
    rd(IS, 8'h00, OK); // status write cleared it
    // seven falls after the reload leave bit 7 on the wire, the eighth ends it
    PEER.xfer(1, 7, 8'h00);
    rd(sa(1), 8'h84, OK); // last bit still shifting
    PEER.xfer(1, 1, 8'h00);
    chk({24'h0, PEER.got}, 32'h5a); // second byte
    rd(sa(1), 8'h80, OK); // idle after last bit
    rd(IS, 8'h02, OK); // only receive pending
    close_out;
  end
endmodule
